// >>> hdl/uief_pkg.sv
// package: register map, field positions and carrier types of the uart interrupt block
package uief_pkg;

    // ------------------------------------------------------------------
    // register map
    // ------------------------------------------------------------------
    localparam logic [7:0]  UIEF_OFS_IRQ_ENABLE = 8'h0c;
    localparam logic [7:0]  UIEF_OFS_IRQ_FLAGS  = 8'h10;
    localparam logic [7:0]  UIEF_OFS_CTRL_ONE   = 8'h04;
    localparam logic [7:0]  UIEF_OFS_FIFO_LVL   = 8'h08;
    localparam logic [31:0] UIEF_RST_IRQ_ENABLE = 32'h0000_0000;
    localparam logic [31:0] UIEF_RST_IRQ_FLAGS  = 32'h0000_0000;
    localparam logic [31:0] UIEF_RST_CTRL_ONE   = 32'h0000_0000;

    // ------------------------------------------------------------------
    // field layout
    // ------------------------------------------------------------------
    localparam int UIEF_NUM_SRC        = 10;
    localparam int UIEF_BIT_FRAME      = 0;
    localparam int UIEF_BIT_PARITY     = 1;
    localparam int UIEF_BIT_CTS        = 2;
    localparam int UIEF_BIT_OVERRUN    = 3;
    localparam int UIEF_BIT_RX_LVL     = 4;
    localparam int UIEF_BIT_TX_AE      = 5;
    localparam int UIEF_BIT_TX_LVL     = 6;
    localparam int UIEF_BIT_FIRST_BRK  = 7;
    localparam int UIEF_BIT_RX_TIMEOUT = 8;
    localparam int UIEF_BIT_LAST_BRK   = 9;
    localparam int UIEF_LVL_W          = 6;
    localparam int UIEF_RX_LVL_LSB     = 0;
    localparam int UIEF_TX_LVL_LSB     = 8;
    localparam int UIEF_RX_NUM_LSB     = 8;
    localparam int UIEF_TX_NUM_LSB     = 16;
    localparam logic [5:0] UIEF_FIFO_DEPTH = 6'h20;
    localparam logic [5:0] UIEF_ONE_ENTRY  = 6'h01;

    // ------------------------------------------------------------------
    // carrier types
    // ------------------------------------------------------------------
    // raw events from the receiver, one cycle each
    typedef struct packed {
        logic rx_break_frame;     // a break frame was received
        logic rx_char_done;       // a regular character was received
        logic rx_frame_err;
        logic rx_parity_err;
        logic rx_push;            // a byte is written into the rx fifo
        logic receive_timeout_event;
    } uief_evt_type;

    typedef struct packed {
        logic [5:0] rx_count;
        logic [5:0] tx_count;
    } uief_lvl_type;

endpackage : uief_pkg

// >>> hdl/uief_sync.sv
// module: two-stage synchroniser with a change pulse on the resynchronised level
`timescale 1ns/1ps
module uief_sync
    import uief_pkg::*;
(
    input  wire logic i_clk_sys,
    input  wire logic i_rst_b,
    input  wire logic i_async,
    output logic      o_level,
    output logic      o_change
);
    logic meta_reg, meta_next;
    logic sync_reg, sync_next;
    logic last_reg, last_next;

    // ------------------------------------------------------------------
    // next state
    // ------------------------------------------------------------------
    always_comb begin
        meta_next = i_async;
        sync_next = meta_reg;   // only the second stage reads the first
        last_next = sync_reg;
    end

    // the pin idles high, so reset to high to avoid a false change
    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_b) begin
            meta_reg <= 1'b1;
            sync_reg <= 1'b1;
            last_reg <= 1'b1;
        end else begin
            meta_reg <= meta_next;
            sync_reg <= sync_next;
            last_reg <= last_next;
        end
    end

    assign o_level  = sync_reg;
    assign o_change = sync_reg ^ last_reg;
endmodule : uief_sync

// >>> hdl/uief_break_det.sv
// module: tracks runs of break frames and marks their first and last frame
`timescale 1ns/1ps
module uief_break_det
    import uief_pkg::*;
(
    input  wire logic i_clk_sys,
    input  wire logic i_rst_b,
    input  wire logic i_break_frame,
    input  wire logic i_char_done,
    output logic      o_first,
    output logic      o_last
);
    typedef enum logic {BRK_IDLE, BRK_RUN} uief_brk_state_type;
    uief_brk_state_type state_reg, state_next;
    logic first_reg, first_next;
    logic last_reg,  last_next;

    // ------------------------------------------------------------------
    // run tracking
    // ------------------------------------------------------------------
    // the last frame of a run is only known once a normal character ends it
    always_comb begin
        state_next = state_reg;
        first_next = 1'b0;
        last_next  = 1'b0;
        case (state_reg)
            BRK_IDLE: begin
                if (i_break_frame) begin
                    state_next = BRK_RUN;
                    first_next = 1'b1;
                end
            end
            BRK_RUN: begin
                if (i_char_done && !i_break_frame) begin
                    state_next = BRK_IDLE;
                    last_next  = 1'b1;
                end
            end
            default: state_next = BRK_IDLE;
        endcase
    end

    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_b) begin
            state_reg <= BRK_IDLE;
            first_reg <= 1'b0;
            last_reg  <= 1'b0;
        end else begin
            state_reg <= state_next;
            first_reg <= first_next;
            last_reg  <= last_next;
        end
    end

    assign o_first = first_reg;
    assign o_last  = last_reg;
endmodule : uief_break_det

// >>> hdl/uief_top.sv
// module: apb register slave with interrupt enables, sticky flags and the request output
`timescale 1ns/1ps

// What this block does
// - last-break enable bit 9 gates interrupt
// - enable bit 8 gates receive timeout
// - enable bit 7 gates first-break interrupt
// - bit 6: tx count at or below threshold
// - bit 5: exactly one byte in tx fifo
// - bit 4: rx count at or above threshold
// - bit 3: push into full rx fifo
// - bit 2: any change of clear-to-send
// - bit 1: receive parity error
// - bit 0: receive frame error
// - flag bits 31:10 read zero
// - flag 9 set on last break frame
// - write one clears flag, zero keeps
// - first-break flag set on first break frame
// - almost-empty flag set at one byte left
module uief_top
    import uief_pkg::*;
(
    input  wire logic         i_clk_sys,
    input  wire logic         i_rst_b,
    input  wire logic         i_psel,
    input  wire logic         i_penable,
    input  wire logic         i_pwrite,
    input  wire logic [7:0]   i_paddr,
    input  wire logic [31:0]  i_pwdata,
    output logic      [31:0]  o_prdata,
    output logic              o_pready,
    output logic              o_pslverr,
    input  wire uief_evt_type i_evt,
    input  wire uief_lvl_type i_lvl,
    input  wire logic         i_cts_pin,
    output logic [UIEF_LVL_W-1:0] o_rx_threshold,
    output logic [UIEF_LVL_W-1:0] o_tx_threshold,
    output logic              o_irq
);
    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    logic [UIEF_NUM_SRC-1:0] enable_reg, enable_next;
    logic [UIEF_NUM_SRC-1:0] flags_reg,  flags_next;
    logic [31:0]             enable_rsvd_reg, enable_rsvd_next;
    logic [31:0]             ctrl_reg,   ctrl_next;
    logic [31:0]             prdata_reg, prdata_next;
    logic [UIEF_NUM_SRC-1:0] set_vec;
    logic [UIEF_NUM_SRC-1:0] clr_vec;
    logic                    cts_level;
    logic                    cts_change;
    logic                    brk_first;
    logic                    brk_last;
    logic                    access;
    logic                    wr_en;
    logic                    rd_en;
    logic                    rx_full;
    logic [UIEF_LVL_W-1:0]   rx_thr;
    logic [UIEF_LVL_W-1:0]   tx_thr;

    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------
    // true for any mapped word address; used by the error path only, the read decode compares addresses itself
    function automatic logic is_mapped(input logic [7:0] addr);
        is_mapped = (addr == UIEF_OFS_IRQ_ENABLE) || (addr == UIEF_OFS_IRQ_FLAGS) ||
                    (addr == UIEF_OFS_CTRL_ONE)   || (addr == UIEF_OFS_FIFO_LVL);
    endfunction : is_mapped

    // ------------------------------------------------------------------
    // clear-to-send input and break run tracking
    // ------------------------------------------------------------------
    uief_sync u_cts_sync (
        .i_clk_sys (i_clk_sys),
        .i_rst_b   (i_rst_b),
        .i_async   (i_cts_pin),
        .o_level   (cts_level),
        .o_change  (cts_change)
    );

    uief_break_det u_break_det (
        .i_clk_sys     (i_clk_sys),
        .i_rst_b       (i_rst_b),
        .i_break_frame (i_evt.rx_break_frame),
        .i_char_done   (i_evt.rx_char_done),
        .o_first       (brk_first),
        .o_last        (brk_last)
    );

    // ------------------------------------------------------------------
    // apb access decode
    // ------------------------------------------------------------------
    // zero wait states: every access completes in its first access cycle
    assign access    = i_psel && i_penable;
    assign wr_en     = access && i_pwrite;
    assign rd_en     = i_psel && !i_penable && !i_pwrite;
    assign o_pready  = 1'b1;
    assign o_pslverr = access && !is_mapped(i_paddr);
    assign o_prdata  = prdata_reg;

    // threshold fields; values above 32 are software's fault, used as given
    assign rx_thr = ctrl_reg[UIEF_RX_LVL_LSB +: UIEF_LVL_W];
    assign tx_thr = ctrl_reg[UIEF_TX_LVL_LSB +: UIEF_LVL_W];
    assign o_rx_threshold = rx_thr;
    assign o_tx_threshold = tx_thr;
    assign rx_full = (i_lvl.rx_count >= UIEF_FIFO_DEPTH);

    // ------------------------------------------------------------------
    // event sources
    // ------------------------------------------------------------------
    // level sources re-set the flag each cycle the condition holds, so a
    // clear only sticks once software has moved the fifo level
    always_comb begin
        set_vec = '0;
        set_vec[UIEF_BIT_FRAME]      = i_evt.rx_frame_err;
        set_vec[UIEF_BIT_PARITY]     = i_evt.rx_parity_err;
        set_vec[UIEF_BIT_CTS]        = cts_change;
        set_vec[UIEF_BIT_OVERRUN]    = i_evt.rx_push && rx_full;
        set_vec[UIEF_BIT_RX_LVL]     = (i_lvl.rx_count >= rx_thr);
        set_vec[UIEF_BIT_TX_AE]      = (i_lvl.tx_count == UIEF_ONE_ENTRY);
        set_vec[UIEF_BIT_TX_LVL]     = (i_lvl.tx_count <= tx_thr);
        set_vec[UIEF_BIT_FIRST_BRK]  = brk_first;
        set_vec[UIEF_BIT_RX_TIMEOUT] = i_evt.receive_timeout_event;
        set_vec[UIEF_BIT_LAST_BRK]   = brk_last;
    end

    // ------------------------------------------------------------------
    // register next values
    // ------------------------------------------------------------------
    always_comb begin
        enable_next      = enable_reg;
        enable_rsvd_next = enable_rsvd_reg;
        ctrl_next        = ctrl_reg;
        clr_vec          = '0;
        prdata_next      = prdata_reg;
        if (wr_en) begin
            if (i_paddr == UIEF_OFS_IRQ_ENABLE) begin
                enable_next      = i_pwdata[UIEF_NUM_SRC-1:0];
                // upper bits are plain storage; software is to write them back
                enable_rsvd_next = {i_pwdata[31:UIEF_NUM_SRC], {UIEF_NUM_SRC{1'b0}}};
            end else if (i_paddr == UIEF_OFS_IRQ_FLAGS) begin
                clr_vec = i_pwdata[UIEF_NUM_SRC-1:0];
            end else if (i_paddr == UIEF_OFS_CTRL_ONE) begin
                ctrl_next = i_pwdata;
            end
        end
        // capture read data in the setup cycle so it stands through access
        if (rd_en) begin
            if (i_paddr == UIEF_OFS_IRQ_ENABLE) begin
                prdata_next = enable_rsvd_reg | {22'h0, enable_reg};
            end else if (i_paddr == UIEF_OFS_IRQ_FLAGS) begin
                prdata_next = {22'h0, flags_reg};
            end else if (i_paddr == UIEF_OFS_CTRL_ONE) begin
                prdata_next = ctrl_reg;
            end else if (i_paddr == UIEF_OFS_FIFO_LVL) begin
                // cts at bit 24, tx count at 21:16, rx count at 13:8
                prdata_next = {7'h0, cts_level, 2'h0, i_lvl.tx_count,
                               2'h0, i_lvl.rx_count, 8'h00};
            end else begin
                prdata_next = 32'h0000_0000;
            end
        end
        // set wins over a clear in the same cycle
        flags_next = (flags_reg & ~clr_vec) | set_vec;
    end

    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_b) begin
            enable_reg      <= UIEF_RST_IRQ_ENABLE[UIEF_NUM_SRC-1:0];
            enable_rsvd_reg <= UIEF_RST_IRQ_ENABLE;
            flags_reg       <= UIEF_RST_IRQ_FLAGS[UIEF_NUM_SRC-1:0];
            ctrl_reg        <= UIEF_RST_CTRL_ONE;
            prdata_reg      <= 32'h0000_0000;
        end else begin
            enable_reg      <= enable_next;
            enable_rsvd_reg <= enable_rsvd_next;
            flags_reg       <= flags_next;
            ctrl_reg        <= ctrl_next;
            prdata_reg      <= prdata_next;
        end
    end

    // ------------------------------------------------------------------
    // interrupt request
    // ------------------------------------------------------------------
    // each flag only reaches the output through its own enable bit
    assign o_irq = |(flags_reg & enable_reg);

endmodule : uief_top

// >>> verif/uief_properties.sv
// checker: request and apb answer properties of the uart interrupt block
`timescale 1ns/1ps
module uief_properties
    import uief_pkg::*;
(
    input wire logic         i_clk_sys,
    input wire logic         i_rst_b,
    input wire logic         i_psel,
    input wire logic         i_penable,
    input wire logic         i_pwrite,
    input wire logic [7:0]   i_paddr,
    input wire logic [31:0]  i_pwdata,
    input wire logic [31:0]  o_prdata,
    input wire logic         o_pready,
    input wire logic         o_pslverr,
    input wire uief_evt_type i_evt,
    input wire uief_lvl_type i_lvl,
    input wire logic         i_cts_pin,
    input wire logic [UIEF_LVL_W-1:0] o_rx_threshold,
    input wire logic [UIEF_LVL_W-1:0] o_tx_threshold,
    input wire logic         o_irq
);
    // ------------------------------------------------------------------
    // enable shadow, so each source can be judged against its own bit
    // ------------------------------------------------------------------
    logic [9:0] en_reg;
    logic       quiet;
    logic       acc;
    assign acc   = i_psel && i_penable;
    assign quiet = !(acc && i_pwrite); // a write may move enables or clear flags
    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_b) en_reg <= 10'h000;
        else if (acc && i_pwrite && i_paddr == UIEF_OFS_IRQ_ENABLE) en_reg <= i_pwdata[9:0];
    end

    default clocking @(posedge i_clk_sys); endclocking
    default disable iff (!i_rst_b);

    chk_frame_irq: assert property (
        quiet && en_reg[0] && i_evt.rx_frame_err |=> o_irq) else $error("frame irq missing");
    chk_parity_irq: assert property (
        quiet && en_reg[1] && i_evt.rx_parity_err |=> o_irq) else $error("parity irq missing");
    chk_timeout_irq: assert property (
        quiet && en_reg[8] && i_evt.receive_timeout_event |=> o_irq)
        else $error("timeout irq missing");
    chk_overrun_irq: assert property (
        quiet && en_reg[3] && i_evt.rx_push && i_lvl.rx_count >= UIEF_FIFO_DEPTH |=> o_irq)
        else $error("overrun irq missing");
    chk_rx_level_irq: assert property (
        quiet && en_reg[4] && i_lvl.rx_count >= o_rx_threshold |=> o_irq)
        else $error("rx level irq missing");
    chk_tx_level_irq: assert property (
        quiet && en_reg[6] && i_lvl.tx_count <= o_tx_threshold |=> o_irq)
        else $error("tx level irq missing");
    chk_tx_empty_irq: assert property (
        quiet && en_reg[5] && i_lvl.tx_count == UIEF_ONE_ENTRY |=> o_irq)
        else $error("almost empty irq missing");
    chk_cts_irq: assert property (
        $changed(i_cts_pin) && en_reg[2] && quiet ##1 quiet [*3] |=> o_irq)
        else $error("cts irq missing");
    chk_masked_quiet: assert property (
        en_reg == 10'h000 |-> !o_irq) else $error("irq with all sources masked");
    chk_flag_upper: assert property (
        acc && !i_pwrite && i_paddr == UIEF_OFS_IRQ_FLAGS |-> o_prdata[31:10] == 22'h0)
        else $error("flag upper bits not zero");
endmodule : uief_properties

bind uief_top uief_properties uief_properties_i (.i_clk_sys, .i_rst_b, .i_psel, .i_penable,
    .i_pwrite, .i_paddr, .i_pwdata, .o_prdata, .o_pready, .o_pslverr, .i_evt, .i_lvl,
    .i_cts_pin, .o_rx_threshold, .o_tx_threshold, .o_irq);

// >>> verif/uief_remote.sv
// partner model: far-side receiver events, fifo levels and cts pin
`timescale 1ns/1ps
module uief_remote
    import uief_pkg::*;
(
    input  wire logic   i_clk_sys,
    output uief_evt_type o_evt,
    output uief_lvl_type o_lvl,
    output logic         o_cts_pin
);
    // idle levels keep every level source quiet with rx threshold 32, tx threshold 3
    initial begin
        o_evt     = '0;
        o_lvl     = '{rx_count: 6'h00, tx_count: 6'h05};
        o_cts_pin = 1'b1;
    end

    task automatic pulse(input uief_evt_type e);
        @(posedge i_clk_sys) o_evt <= e;
        @(posedge i_clk_sys) o_evt <= '0;
    endtask : pulse

    // raise the event behind enable bit b, then return levels to idle
    task automatic fire(input int b);
        case (b)
            0: pulse('{rx_frame_err: 1'b1, default: 1'b0});
            1: pulse('{rx_parity_err: 1'b1, default: 1'b0});
            2: @(posedge i_clk_sys) o_cts_pin <= !o_cts_pin;
            3: begin
                @(posedge i_clk_sys) o_lvl.rx_count <= UIEF_FIFO_DEPTH;
                pulse('{rx_push: 1'b1, default: 1'b0});
            end
            4: @(posedge i_clk_sys) o_lvl.rx_count <= UIEF_FIFO_DEPTH;
            5: @(posedge i_clk_sys) o_lvl.tx_count <= UIEF_ONE_ENTRY;
            6: @(posedge i_clk_sys) o_lvl.tx_count <= 6'h00;
            8: pulse('{receive_timeout_event: 1'b1, default: 1'b0});
            // a break run ends on the next regular character; 7 ends it too so
            // that a later run starts afresh and marks its first frame again
            default: begin
                pulse('{rx_break_frame: 1'b1, default: 1'b0});
                pulse('{rx_char_done: 1'b1, default: 1'b0});
            end
        endcase
        @(posedge i_clk_sys) o_lvl <= '{rx_count: 6'h00, tx_count: 6'h05};
    endtask : fire
endmodule : uief_remote

// >>> verif/uart_interrupt_enable_flags_tb_top.sv
// testbench: apb register access and per-source interrupt checks
`timescale 1ns/1ps
module uart_interrupt_enable_flags_tb_top
    import uief_pkg::*;
;
    logic         i_clk_sys = 1'b0;
    logic         i_rst_b   = 1'b0;
    logic         psel      = 1'b0;
    logic         penable   = 1'b0;
    logic         pwrite    = 1'b0;
    logic [7:0]   paddr     = 8'h00;
    logic [31:0]  pwdata    = 32'h0;
    logic [31:0]  prdata;
    logic [31:0]  q;
    logic [31:0]  m;
    logic         pready, pslverr, slv, irq, cts;
    logic [5:0]   rx_thr, tx_thr;
    uief_evt_type evt;
    uief_lvl_type lvl;
    int           err_count   = 0;
    int           check_count = 0;

    always #2.5 i_clk_sys = ~i_clk_sys;

    uief_top uief_top_i (.i_clk_sys, .i_rst_b, .i_psel(psel), .i_penable(penable),
        .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
        .o_pready(pready), .o_pslverr(pslverr), .i_evt(evt), .i_lvl(lvl), .i_cts_pin(cts),
        .o_rx_threshold(rx_thr), .o_tx_threshold(tx_thr), .o_irq(irq));
    uief_remote uief_remote_i (.i_clk_sys, .o_evt(evt), .o_lvl(lvl), .o_cts_pin(cts));

    // ------------------------------------------------------------------
    // apb master and compare helpers
    // ------------------------------------------------------------------
    // waits for pready however long it takes; only the hang guard ends a stuck wait
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge i_clk_sys);
        psel <= 1'b1; pwrite <= wr; paddr <= a; pwdata <= d;
        @(posedge i_clk_sys) penable <= 1'b1;
        do begin @(posedge i_clk_sys); end while (pready !== 1'b1);
        q   = prdata; // taken at the completing edge only
        slv = pslverr;
        psel <= 1'b0; penable <= 1'b0;
        #1;
    endtask : apb

    task automatic check(input string nm, input logic [31:0] exp, input logic [31:0] got);
        check_count++;
        if (got !== exp) begin
            err_count++;
            $display("unexpected %s: expected %h, seen %h", nm, exp, got);
        end
    endtask : check

    task automatic end_sim;
        if (err_count == 0 && check_count > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : end_sim

    // ------------------------------------------------------------------
    // test sequence
    // ------------------------------------------------------------------
    initial begin
        repeat (10) @(posedge i_clk_sys);
        i_rst_b <= 1'b1;
        apb(0, UIEF_OFS_IRQ_ENABLE, 0); check("enable reset", 32'h0, q);
        check("pready", 32'h1, {31'h0, pready});
        apb(0, UIEF_OFS_IRQ_FLAGS, 0);  check("flags reset", 32'h10, q);
        apb(1, UIEF_OFS_CTRL_ONE, 32'h320); check("rx threshold", 32'h20, {26'h0, rx_thr});
        check("tx threshold", 32'h3, {26'h0, tx_thr});
        apb(0, UIEF_OFS_CTRL_ONE, 0); check("control rw", 32'h320, q);
        // idle partner: cts high, five bytes queued for transmit, receive fifo empty
        apb(0, UIEF_OFS_FIFO_LVL, 0); check("level status", 32'h0105_0000, q);
        apb(1, UIEF_OFS_IRQ_FLAGS, 32'hffff_ffff);
        apb(0, UIEF_OFS_IRQ_FLAGS, 0); check("flags cleared", 32'h0, q);
        apb(0, 8'hfc, 0); check("unmapped", 32'h1, {q[30:0], slv});
        apb(1, UIEF_OFS_IRQ_ENABLE, 32'h3ff);
        apb(0, UIEF_OFS_IRQ_ENABLE, 0); check("enable rw", 32'h3ff, q);
        // every source: enabled raise, w1c behaviour, then masked raise
        for (int b = 0; b < UIEF_NUM_SRC; b++) begin
            m = 32'h1 << b;
            apb(1, UIEF_OFS_IRQ_ENABLE, m);
            apb(1, UIEF_OFS_IRQ_FLAGS, 32'h3ff);
            uief_remote_i.fire(b);
            repeat (4) @(posedge i_clk_sys);
            #1;
            check("irq raised", 32'h1, {31'h0, irq});
            apb(0, UIEF_OFS_IRQ_FLAGS, 0); check("flag set", m, q & m);
            apb(1, UIEF_OFS_IRQ_FLAGS, 0);
            apb(0, UIEF_OFS_IRQ_FLAGS, 0); check("flag kept", m, q & m);
            apb(1, UIEF_OFS_IRQ_FLAGS, m);
            apb(0, UIEF_OFS_IRQ_FLAGS, 0); check("flag clr", 32'h0, q & m);
            check("irq after clr", 32'h0, {31'h0, irq});
            apb(1, UIEF_OFS_IRQ_ENABLE, 0);
            uief_remote_i.fire(b);
            repeat (4) @(posedge i_clk_sys);
            #1;
            check("irq masked", 32'h0, {31'h0, irq});
            apb(1, UIEF_OFS_IRQ_ENABLE, m);
            check("irq unmasked", 32'h1, {31'h0, irq});
        end
        end_sim();
    end

    // hang guard, far beyond the few hundred cycles the sequence needs
    initial begin
        #400000;
        err_count++;
        end_sim();
    end
endmodule : uart_interrupt_enable_flags_tb_top
